/* File: common/timekeeper_pkg.sv */
package timekeeper_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [11:0] power_gate_control_2_index = 12'hF76;
  localparam logic [11:0] timekeeper_control_index = 12'hFC8;
  localparam logic [11:0] irq_status_index = 12'hFCC;
  localparam logic [11:0] irq_mask_index = 12'hFD4;
  localparam logic [11:0] status_view_index = 12'hFD8;
  // Byte addresses on the register bus
  localparam logic [13:0] power_gate_control_2_addr = {power_gate_control_2_index, 2'b00};
  localparam logic [13:0] timekeeper_control_addr = {timekeeper_control_index, 2'b00};
  localparam logic [13:0] irq_status_addr = {irq_status_index, 2'b00};
  localparam logic [13:0] irq_mask_addr = {irq_mask_index, 2'b00};
  localparam logic [13:0] status_view_addr = {status_view_index, 2'b00};
  // Field positions
  localparam int gate_bit = 5;
  localparam int serial_gate_bit = 0;
  localparam int run_bit = 0;
  localparam int sel_lsb = 1;
  localparam int sel_width = 3;
  // Reset values
  localparam logic [7:0] power_gate_reset = 8'h00;
  localparam logic [7:0] control_reset = 8'h00;
  // Interval range as powers of two
  localparam int longest_interval_log2 = 15;
  localparam int shortest_interval_log2 = 8;
endpackage

/* File: verilog/periodic_interval_timekeeper.sv */
// Functional notes
// - base clock reaches counter only when gated on
// - clock gate bit resets to zero
// - run bit set starts counting low-frequency periods
// - interval is two to fifteen-minus-code periods
// - interval reached raises interrupt, counting continues
// - run cleared zeroes and stops counter
// - select writes ignored while running
// - select accepted while stopped, with run set or clear
// - run bit zero after reset
// - oscillator off or stop clears run
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module periodic_interval_timekeeper #(
  parameter int counter_width = 15
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_freq_clock_i,
  input wire logic low_freq_osc_enable_i,
  input wire logic stop_mode_i,
  input wire logic deep_sleep_zero_mode_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic periodic_interrupt_request_o,
  output logic irq_o
);

  // Elaboration checks: counter spans the longest interval exactly
  if (counter_width != timekeeper_pkg::longest_interval_log2) begin : g_width_check
    $error("counter_width must equal the longest interval exponent");
  end
  // Select field must name every interval from longest to shortest
  if ((1 << timekeeper_pkg::sel_width) !=
      (timekeeper_pkg::longest_interval_log2 - timekeeper_pkg::shortest_interval_log2 + 1)) begin : g_sel_check
    $error("select field width does not cover the interval range");
  end
  // Shortest interval must leave room for the counter to roll through it
  if (timekeeper_pkg::shortest_interval_log2 < 1) begin : g_short_check
    $error("shortest interval exponent must be at least one");
  end
  // Gate bit and control fields must sit inside the eight-bit registers
  if (timekeeper_pkg::gate_bit > 7) begin : g_gate_check
    $error("gate bit lies outside the power gate register");
  end
  if (timekeeper_pkg::sel_lsb + timekeeper_pkg::sel_width > 4) begin : g_field_check
    $error("select field reaches the read-as-zero upper bits");
  end
  if (timekeeper_pkg::run_bit != 0 || timekeeper_pkg::sel_lsb != 1) begin : g_run_check
    $error("read-back packs run at bit zero and select just above it");
  end
  // Register addresses must be distinct
  if (timekeeper_pkg::power_gate_control_2_addr == timekeeper_pkg::timekeeper_control_addr) begin : g_addr_check
    $error("power gate and control share an address");
  end
  if (timekeeper_pkg::irq_status_addr == timekeeper_pkg::irq_mask_addr ||
      timekeeper_pkg::irq_mask_addr == timekeeper_pkg::status_view_addr ||
      timekeeper_pkg::irq_status_addr == timekeeper_pkg::status_view_addr) begin : g_own_addr_check
    $error("interrupt and counter view registers share an address");
  end

  // Power gate register: all eight bits are stored, bit 5 also gates the clock
  logic [7:0] gate_q;
  logic [7:0] gate_d;

  // Control register: run bit and interval select
  logic run_q;
  logic run_d;
  logic [timekeeper_pkg::sel_width-1:0] sel_q;
  logic [timekeeper_pkg::sel_width-1:0] sel_d;

  // Interval counter in low-frequency periods
  logic [counter_width-1:0] count_q;
  logic [counter_width-1:0] count_d;

  // Two synchroniser flops plus one edge history flop
  logic [2:0] lf_q;
  logic [2:0] lf_d;

  // Sticky interrupt status and its mask
  logic status_q;
  logic status_d;
  logic mask_q;
  logic mask_d;

  // Next values of the registered outputs
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic pulse_d;
  logic irq_d;

  // Bus phase strobes
  logic access;
  logic commit;
  logic lane0;
  logic wr;
  logic rd;

  // Register selects
  logic hit_power_gate;
  logic hit_control;
  logic hit_status;
  logic hit_mask;
  logic hit_count;
  logic writable;
  logic readable;

  // Timer strobes
  logic gate_on;
  logic lf_rise;
  logic force_stop;
  logic period_end;
  logic [counter_width-1:0] interval_mask;

  // First access cycle: the answer is prepared and pready raised
  assign access = psel_i && penable_i && !pready_o;
  // Last access cycle: the master samples pready high on this edge, writes land here
  assign commit = psel_i && penable_i && pready_o;
  // Byte lane zero carries every writable register
  assign lane0 = pstrb_i[0];
  assign wr = commit && pwrite_i && lane0;
  assign rd = access && !pwrite_i;

  // Address decode on byte addresses
  assign hit_power_gate = (paddr_i == timekeeper_pkg::power_gate_control_2_addr);
  assign hit_control = (paddr_i == timekeeper_pkg::timekeeper_control_addr);
  assign hit_status = (paddr_i == timekeeper_pkg::irq_status_addr);
  assign hit_mask = (paddr_i == timekeeper_pkg::irq_mask_addr);
  assign hit_count = (paddr_i == timekeeper_pkg::status_view_addr);
  // Counter view is read only, so a write to it is refused
  assign writable = hit_power_gate || hit_control || hit_status || hit_mask;
  assign readable = writable || hit_count;

  // Clock gate: without it no low-frequency edge reaches the timer
  assign gate_on = gate_q[timekeeper_pkg::gate_bit];
  // Rising edge seen by the second synchroniser flop, counted only with gate on
  assign lf_rise = lf_q[1] && !lf_q[2] && gate_on;
  // Oscillator stop, stop mode and deep sleep zero all end a run
  assign force_stop = !low_freq_osc_enable_i || stop_mode_i || deep_sleep_zero_mode_i;

  // Interval mask: ones below the selected exponent, 15 - code bits in all
  for (genvar b = 0; b < counter_width; b++) begin : g_mask
    assign interval_mask[b] = (b < (timekeeper_pkg::longest_interval_log2 - int'(sel_q)));
  end

  // Period ends on the edge that completes 2^(15 - code) counted periods
  assign period_end = lf_rise && run_q && ((count_q & interval_mask) == interval_mask);

  // Synchroniser next state: shift the pin in
  always_comb begin
    lf_d = {lf_q[1:0], low_freq_clock_i};
  end

  // Synchroniser registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lf_q <= 3'h0;
    end else begin
      lf_q <= lf_d;
    end
  end

  // Power gate and control next state
  always_comb begin
    gate_d = gate_q;
    run_d = run_q;
    sel_d = sel_q;
    // Power gate takes any byte written
    if (wr && hit_power_gate) begin
      gate_d = pwdata_i[7:0];
    end
    // Control writes need the clock gate on
    if (wr && hit_control && gate_on) begin
      run_d = pwdata_i[timekeeper_pkg::run_bit];
      // Select changes only while stopped, so a write that stops keeps it
      if (!run_q) begin
        sel_d = pwdata_i[timekeeper_pkg::sel_lsb +: timekeeper_pkg::sel_width];
      end
    end
    // Forced stop clears run and leaves the select alone
    if (force_stop) begin
      run_d = 1'b0;
    end
  end

  // Power gate and control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_q <= timekeeper_pkg::power_gate_reset;
      run_q <= timekeeper_pkg::control_reset[timekeeper_pkg::run_bit];
      sel_q <= timekeeper_pkg::control_reset[timekeeper_pkg::sel_lsb +: timekeeper_pkg::sel_width];
    end else begin
      gate_q <= gate_d;
      run_q <= run_d;
      sel_q <= sel_d;
    end
  end

  // Counter next state: held at zero while stopped, steps on each counted edge
  always_comb begin
    count_d = count_q;
    // Stopped: the count restarts from zero
    if (!run_q) begin
      count_d = '0;
    end else if (lf_rise) begin
      count_d = count_q + 1'b1;
    end
  end

  // Counter register; it wraps through every interval without stopping
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Interrupt next state: set on period end, write one to clear, set wins
  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    // Mask takes bit zero
    if (wr && hit_mask) begin
      mask_d = pwdata_i[0];
    end
    // Writing one clears the status
    if (wr && hit_status && pwdata_i[0]) begin
      status_d = 1'b0;
    end
    // Period end sets it again in the same cycle
    if (period_end) begin
      status_d = 1'b1;
    end
    pulse_d = period_end;
    irq_d = status_d && mask_d;
  end

  // Interrupt registers and the two interrupt outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= 1'b0;
      mask_q <= 1'b0;
      periodic_interrupt_request_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      periodic_interrupt_request_o <= pulse_d;
      irq_o <= irq_d;
    end
  end

  // Bus answer next state: one-cycle ready, read data with it, error on unmapped
  always_comb begin
    pready_d = access;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    // Unmapped read or write ends in an error with zero data
    if (access && !pwrite_i && !readable) begin
      pslverr_d = 1'b1;
    end
    if (access && pwrite_i && !writable) begin
      pslverr_d = 1'b1;
    end
    // Read data multiplexer, one register per address
    if (rd && hit_power_gate) begin
      prdata_d = {24'h00_0000, gate_q};
    end
    if (rd && hit_control) begin
      prdata_d = {28'h000_0000, sel_q, run_q};
    end
    if (rd && hit_status) begin
      prdata_d = {31'h0000_0000, status_q};
    end
    if (rd && hit_mask) begin
      prdata_d = {31'h0000_0000, mask_q};
    end
    if (rd && hit_count) begin
      prdata_d = {{(32 - counter_width){1'b0}}, count_q};
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      prdata_o <= prdata_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
    end
  end

endmodule

`default_nettype wire

/* File: sim/timekeeper_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module timekeeper_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_freq_osc_enable_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic periodic_interrupt_request_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Bus answer and register read-back
  ready_next_a: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("late ready");
  ready_once_a: assert property (pready_o |=> !pready_o) else $error("long ready");
  error_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error");
  ctl_upper_a: assert property (pready_o && !pwrite_i && paddr_i == timekeeper_pkg::timekeeper_control_addr
    |-> prdata_o[31:4] == 28'h0)
    else $error("upper bits set");
  // Interval pulse and interrupt line
  osc_quiet_a: assert property (!low_freq_osc_enable_i [*8] |-> !periodic_interrupt_request_o)
    else $error("pulse with oscillator off");
  pulse_gap_a: assert property (periodic_interrupt_request_o |=> !periodic_interrupt_request_o [*8])
    else $error("pulses too close");
  irq_rise_a: assert property ($rose(irq_o) |-> periodic_interrupt_request_o || $past(pready_o) || $past(pready_o, 2))
    else $error("irq rose alone");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(pready_o) || $past(pready_o, 2)) else $error("irq fell alone");
  cover property (periodic_interrupt_request_o);
  cover property (irq_o);
  cover property (pslverr_o);
endmodule
bind periodic_interval_timekeeper timekeeper_assertions timekeeper_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
  .low_freq_osc_enable_i(low_freq_osc_enable_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .periodic_interrupt_request_o(periodic_interrupt_request_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/periodic_interval_timekeeper_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module periodic_interval_timekeeper_tb;
  localparam logic [13:0] ctl = timekeeper_pkg::timekeeper_control_addr;
  localparam logic [13:0] gcr = timekeeper_pkg::power_gate_control_2_addr;
  logic stop_q = 1'b0;
  logic slp_q = 1'b0;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc_q = 1'b1;
  logic sel_q = 1'b0;
  logic en_q = 1'b0;
  logic wr_q = 1'b0;
  logic [13:0] adr_q = 14'h0000;
  logic [31:0] wd_q = 32'h0;
  logic [2:0] lf_q = 3'h0;
  logic [31:0] rd, rd_q;
  logic rdy, err, pulse, irq, err_q;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int gap;
  periodic_interval_timekeeper periodic_interval_timekeeper_i (.clk_i(clk_i), .rst_i(rst_i),
    .low_freq_clock_i(lf_q[2]), .low_freq_osc_enable_i(osc_q), .stop_mode_i(stop_q), .deep_sleep_zero_mode_i(slp_q),
    .psel_i(sel_q), .penable_i(en_q), .pwrite_i(wr_q), .paddr_i(adr_q), .pwdata_i(wd_q), .pstrb_i(4'hF),
    .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .periodic_interrupt_request_o(pulse), .irq_o(irq));
  // Bus clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Slow clock at an eighth of the bus clock, and hang guard
  always @(posedge clk_i) begin
    lf_q <= lf_q + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    sel_q <= 1'b1;
    wr_q <= w;
    adr_q <= a;
    wd_q <= d;
    @(posedge clk_i);
    en_q <= 1'b1;
    @(posedge clk_i);
    while (rdy !== 1'b1) @(posedge clk_i);
    rd_q = rd;
    err_q = err;
    sel_q <= 1'b0;
    en_q <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_pulse;
    gap = 1;
    @(posedge clk_i);
    while (pulse !== 1'b1) begin
      gap = gap + 1;
      @(posedge clk_i);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(0, gcr, 0); chk(rd_q, 32'h0);
    xfer(0, ctl, 0); chk(rd_q, 32'h0);
    xfer(1, ctl, 32'hF);
    xfer(0, ctl, 0); chk(rd_q, 32'h0);
    xfer(1, gcr, 32'h20);
    xfer(1, timekeeper_pkg::irq_mask_addr, 32'h1);
    xfer(1, ctl, 32'hF);
    xfer(1, ctl, 32'h3);
    xfer(0, ctl, 0); chk(rd_q, 32'hF);
    wait_pulse;
    wait_pulse;
    chk(gap, 32'd2048);
    chk(irq, 32'h1);
    xfer(1, timekeeper_pkg::irq_status_addr, 32'h1);
    chk(irq, 32'h0);
    xfer(1, ctl, 32'h0);
    xfer(0, ctl, 0); chk(rd_q, 32'hE);
    xfer(0, timekeeper_pkg::status_view_addr, 0); chk(rd_q, 32'h0);
    xfer(1, ctl, 32'hF);
    osc_q <= 1'b0;
    repeat (8) @(posedge clk_i);
    xfer(0, ctl, 0); chk(rd_q, 32'hE);
    osc_q <= 1'b1;
    xfer(1, ctl, 32'hF);
    stop_q <= 1'b1;
    repeat (8) @(posedge clk_i);
    xfer(0, ctl, 0); chk(rd_q, 32'hE);
    stop_q <= 1'b0;
    xfer(1, ctl, 32'hF);
    slp_q <= 1'b1;
    repeat (8) @(posedge clk_i);
    xfer(0, ctl, 0); chk(rd_q, 32'hE);
    slp_q <= 1'b0;
    xfer(0, 14'h0000, 0); chk(err_q, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
